// [rtl/pin_remap_lock.sv]
// remappable pin mapping registers with write lock, shadow check and input select
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps
// Notes on behaviour
// - locked mapping writes complete but change nothing
// - lock bit sits at control bit six
// - keys 0x46 then 0x57 precede lock change
// - lock stays until deliberately changed
// - shadow copies mismatch triggers configuration reset
// - single session option blocks clearing set lock
// - single session locked: keys ignored until reset
// - single session bit defaults set, cleared unlimited
// - analog shared pins read zero after reset
// - digital only when both converter bits one
// - output driver still works on analog pins
// - higher priority pin function overrides lower ones
// - sixteen input and thirteen output mapping registers
// - first input register: selector bits 12-8
// - selector picks pin n, all ones grounds
// - output code zero keeps default port logic
module pin_remap_lock
    import pin_remap_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire reg_req_s bus_req,
    output logic [DATA_W-1:0] rdata,
    output logic irq,
    input wire logic [7:0] osc_config_word,
    input wire logic [NUM_RP-1:0] pad_in,
    output pad_drive_s pad_drive,
    input wire logic [NUM_RP-1:0] port_out,
    input wire logic [NUM_RP-1:0] pin_direction_reg,
    input wire logic [NUM_PERIPH-1:0] periph_out,
    output logic [NUM_RP-1:0] digital_in,
    output logic ext_irq1_input,
    output logic mapping_write_lock,
    output logic cfg_mismatch_reset
);
    logic [DATA_W-1:0] in_q [NUM_IN_REGS];
    logic [DATA_W-1:0] in_d [NUM_IN_REGS];
    logic [DATA_W-1:0] in_sh_q [NUM_IN_REGS];
    logic [DATA_W-1:0] in_sh_d [NUM_IN_REGS];
    logic [DATA_W-1:0] out_q [NUM_OUT_REGS];
    logic [DATA_W-1:0] out_d [NUM_OUT_REGS];
    logic [DATA_W-1:0] out_sh_q [NUM_OUT_REGS];
    logic [DATA_W-1:0] out_sh_d [NUM_OUT_REGS];
    logic [DATA_W-1:0] ana1_q, ana1_d, ana2_q, ana2_d, rdata_q, rdata_d;
    logic [EV_W-1:0] status_q, status_d, mask_q, mask_d, ev;
    logic lock_q, lock_d, one_way_q, irq_q, irq_d, mism_q, mism_d;
    key_state_e key_q, key_d;
    logic [7:0] in_off, out_off;
    logic hit_in, hit_out, hit_osc, map_wr;

    // register access and lock
    always_comb begin
        in_off = bus_req.addr - OFS_IN_MAP_BASE;
        out_off = bus_req.addr - OFS_OUT_MAP_BASE;
        hit_in = in_off < 8'(NUM_IN_REGS);
        hit_out = out_off < 8'(NUM_OUT_REGS);
        hit_osc = bus_req.addr == OFS_OSC_CTRL;
        map_wr = bus_req.wr && (hit_in || hit_out);
        in_d = in_q;
        in_sh_d = in_sh_q;
        out_d = out_q;
        out_sh_d = out_sh_q;
        ana1_d = ana1_q;
        ana2_d = ana2_q;
        mask_d = mask_q;
        lock_d = lock_q;
        key_d = key_q;
        ev = '0;
        // mapping writes land in the register and its shadow together
        if (map_wr && !lock_q) begin
            if (hit_in) begin
                in_d[in_off[3:0]] = bus_req.wdata & ((in_off == 8'h00) ? IN0_MASK : IN_MASK);
                in_sh_d[in_off[3:0]] = in_d[in_off[3:0]];
            end else begin
                out_d[out_off[3:0]] = bus_req.wdata & OUT_MASK;
                out_sh_d[out_off[3:0]] = out_d[out_off[3:0]];
            end
        end
        if (map_wr && lock_q) begin
            ev[EV_BLOCKED] = 1'b1;
        end
        if (bus_req.wr && bus_req.addr == OFS_ANA_CFG1) begin
            ana1_d = bus_req.wdata;
        end
        if (bus_req.wr && bus_req.addr == OFS_ANA_CFG2) begin
            ana2_d = bus_req.wdata;
        end
        if (bus_req.wr && bus_req.addr == OFS_IRQ_MASK) begin
            mask_d = bus_req.wdata[EV_W-1:0];
        end
        // any access outside the sequence drops a partial unlock
        if (bus_req.wr || bus_req.rd) begin
            key_d = KEY_IDLE;
        end
        if (bus_req.wr && hit_osc) begin
            case (key_q)
                KEY_GOT2: begin
                    // one-way mode: a set lock sticks until device reset
                    if (!(one_way_q && lock_q)) begin
                        lock_d = bus_req.wdata[LOCK_BIT];
                    end
                end
                KEY_GOT1: begin
                    if (bus_req.wdata[7:0] == UNLOCK_KEY2) begin
                        key_d = KEY_GOT2;
                    end else if (bus_req.wdata[7:0] == UNLOCK_KEY1) begin
                        key_d = KEY_GOT1;
                    end
                end
                default: begin
                    if (bus_req.wdata[7:0] == UNLOCK_KEY1) begin
                        key_d = KEY_GOT1;
                    end
                end
            endcase
        end
        ev[EV_LOCK_CHG] = lock_d != lock_q;
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            for (int i = 0; i < NUM_IN_REGS; i++) begin
                in_q[i] <= (i == 0) ? IN0_RESET : IN_RESET;
                in_sh_q[i] <= (i == 0) ? IN0_RESET : IN_RESET;
            end
            for (int i = 0; i < NUM_OUT_REGS; i++) begin
                out_q[i] <= OUT_RESET;
                out_sh_q[i] <= OUT_RESET;
            end
            ana1_q <= ANA_CFG_RESET;
            ana2_q <= ANA_CFG_RESET;
            mask_q <= EV_MASK_RESET;
            lock_q <= 1'b0;
            key_q <= KEY_IDLE;
            // option bit is caught while reset is held
            one_way_q <= osc_config_word[SINGLE_SESSION_BIT];
        end else begin
            in_q <= in_d;
            in_sh_q <= in_sh_d;
            out_q <= out_d;
            out_sh_q <= out_sh_d;
            ana1_q <= ana1_d;
            ana2_q <= ana2_d;
            mask_q <= mask_d;
            lock_q <= lock_d;
            key_q <= key_d;
        end
    end

    // shadow compare, status, read data
    always_comb begin
        mism_d = 1'b0;
        for (int i = 0; i < NUM_IN_REGS; i++) begin
            mism_d = mism_d | (in_q[i] != in_sh_q[i]);
        end
        for (int i = 0; i < NUM_OUT_REGS; i++) begin
            mism_d = mism_d | (out_q[i] != out_sh_q[i]);
        end
        status_d = status_q;
        rdata_d = '0;
        if (bus_req.rd) begin
            if (hit_osc) begin
                rdata_d[LOCK_BIT] = lock_q;
            end else if (bus_req.addr == OFS_IRQ_STATUS) begin
                rdata_d[EV_W-1:0] = status_q;
                status_d = '0;
            end else if (bus_req.addr == OFS_IRQ_MASK) begin
                rdata_d[EV_W-1:0] = mask_q;
            end else if (bus_req.addr == OFS_ANA_CFG1) begin
                rdata_d = ana1_q;
            end else if (bus_req.addr == OFS_ANA_CFG2) begin
                rdata_d = ana2_q;
            end else if (hit_in) begin
                rdata_d = in_q[in_off[3:0]];
            end else if (hit_out) begin
                rdata_d = out_q[out_off[3:0]];
            end
        end
        // a new event wins over the read that clears
        status_d = status_d | ev;
        status_d[EV_MISMATCH] = status_d[EV_MISMATCH] | mism_d;
        irq_d = |(status_d & mask_d);
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            status_q <= '0;
            rdata_q <= '0;
            irq_q <= 1'b0;
            mism_q <= 1'b0;
        end else begin
            status_q <= status_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
            mism_q <= mism_d;
        end
    end

    // pins
    logic [NUM_RP-1:0] s1_q, s2_q, s3_q, pin_q, pin_d, dig_en, dig_in_d;
    logic [4:0] irq1_sel, code;
    logic irq1_d;
    pad_drive_s drive_d, drive_q;
    logic [NUM_RP-1:0] dig_in_q;
    logic irq1_q;

    always_comb begin
        // a pad change counts only once the last two stages agree
        pin_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & pin_q);
        for (int i = 0; i < NUM_RP; i++) begin
            // analog owns the pin unless both converters release it
            dig_en[i] = (i < NUM_AN) ? (ana1_q[i % NUM_AN] & ana2_q[i % NUM_AN]) : 1'b1;
        end
        dig_in_d = pin_q & dig_en;
        irq1_sel = in_q[0][FIELD_HI +: SEL_W];
        irq1_d = (irq1_sel <= SEL_LAST_PIN) ? dig_in_d[irq1_sel] : 1'b0;
        for (int i = 0; i < NUM_RP; i++) begin
            code = out_q[i / 2][((i % 2) * FIELD_HI) +: SEL_W];
            drive_d.out[i] = (code == OUT_NULL) ? port_out[i] : periph_out[code];
            // the driver stays usable while analog is selected; contention is software's care
            drive_d.oe[i] = !pin_direction_reg[i];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            pin_q <= '0;
            dig_in_q <= '0;
            irq1_q <= 1'b0;
            drive_q <= '0;
        end else begin
            s1_q <= pad_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_q <= pin_d;
            dig_in_q <= dig_in_d;
            irq1_q <= irq1_d;
            drive_q <= drive_d;
        end
    end

    assign rdata = rdata_q;
    assign irq = irq_q;
    assign pad_drive = drive_q;
    assign digital_in = dig_in_q;
    assign ext_irq1_input = irq1_q;
    assign mapping_write_lock = lock_q;
    assign cfg_mismatch_reset = mism_q;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_locked_write_held: assert property (
        bus_req.wr && hit_in && lock_q
        |=> in_q[$past(in_off[3:0])] == $past(in_q[in_off[3:0]]))
        else $error("locked mapping write changed a register");

    a_locked_out_held: assert property (
        bus_req.wr && hit_out && lock_q
        |=> out_q[$past(out_off[3:0])] == $past(out_q[out_off[3:0]]))
        else $error("locked output map write changed a register");

    a_blocked_sets_flag: assert property (
        map_wr && lock_q
        |=> status_q[EV_BLOCKED])
        else $error("blocked mapping write not flagged");

    a_lock_read_bit: assert property (
        bus_req.rd && hit_osc
        |=> rdata[LOCK_BIT] == $past(lock_q))
        else $error("lock bit not read back at bit six");

    a_osc_read_lock_only: assert property (
        bus_req.rd && hit_osc
        |=> (rdata & ~(16'h0001 << LOCK_BIT)) == 16'h0000)
        else $error("control read shows bits beside the lock");

    a_lock_after_keys: assert property (
        $changed(lock_q)
        |-> $past(key_q == KEY_GOT2 && bus_req.wr && hit_osc))
        else $error("lock changed without key sequence");

    a_lock_change_flag: assert property (
        $changed(lock_q)
        |-> status_q[EV_LOCK_CHG])
        else $error("lock change not flagged");

    a_lock_survives_map: assert property (
        !lock_q && map_wr ##1 !(bus_req.wr && hit_osc)
        |=> !lock_q)
        else $error("lock set itself after a mapping write");

    a_lock_holds_still: assert property (
        !(bus_req.wr && hit_osc)
        |=> $stable(mapping_write_lock))
        else $error("lock moved without a control write");

    // only corrupted cells can reach this, so no scenario drives it
    a_mismatch_reset_out: assert property (
        mism_d
        |=> cfg_mismatch_reset ##1 status_q[EV_MISMATCH])
        else $error("shadow mismatch did not raise reset");

    a_one_way_sticky: assert property (
        one_way_q && lock_q
        |=> lock_q)
        else $error("single session lock was cleared");

    a_one_way_keys: assert property (
        one_way_q && lock_q && key_q == KEY_GOT2 && bus_req.wr && hit_osc
        |=> mapping_write_lock)
        else $error("keys cleared a single session lock");

    a_unlimited_sessions: assert property (
        !one_way_q && key_q == KEY_GOT2 && bus_req.wr && hit_osc
        |=> mapping_write_lock == $past(bus_req.wdata[LOCK_BIT]))
        else $error("lock write ignored with sessions unlimited");

    a_analog_reads_zero: assert property (
        !(ana1_q[3] && ana2_q[3])
        |=> !digital_in[3])
        else $error("analog pin read nonzero");

    a_digital_pin_follows: assert property (
        ana1_q[3] && ana2_q[3]
        |=> digital_in[3] == $past(pin_q[3]))
        else $error("digital pin does not follow its pad");

    a_oe_follows_dir: assert property (
        1'b1
        |=> pad_drive.oe == ~$past(pin_direction_reg))
        else $error("output enable does not follow direction");

    a_in0_zero_bits: assert property (
        bus_req.rd && hit_in && in_off == 8'h00
        |=> rdata[15:13] == 3'h0 && rdata[7:0] == 8'h00)
        else $error("unused bits of first input register not zero");

    a_irq1_follows_pin: assert property (
        irq1_sel <= SEL_LAST_PIN
        |=> ext_irq1_input == digital_in[$past(irq1_sel)])
        else $error("interrupt input not routed from selected pin");

    a_irq1_grounded: assert property (
        (irq1_sel == SEL_TIED_LOW) [*2]
        |=> !ext_irq1_input)
        else $error("grounded selector not low");

    a_null_port_out: assert property (
        out_q[0][SEL_W-1:0] == OUT_NULL
        |=> pad_drive.out[0] == $past(port_out[0]))
        else $error("null code not driving port logic");

    a_out_code_drives: assert property (
        out_q[0][SEL_W-1:0] != OUT_NULL
        |=> pad_drive.out[0] == $past(periph_out[out_q[0][SEL_W-1:0]]))
        else $error("output code not driving its peripheral");

    a_key_abort: assert property (
        key_q == KEY_GOT1 && bus_req.rd
        |=> key_q == KEY_IDLE)
        else $error("partial key sequence survived an access");

    c_unlock_done: cover property (key_q == KEY_GOT2 && bus_req.wr && hit_osc ##1 !lock_q);
    c_blocked_write: cover property (map_wr && lock_q);
    c_irq_raised: cover property ($rose(irq));
    c_one_way_locked: cover property (one_way_q && $rose(lock_q));
    c_pin_goes_digital: cover property ($rose(digital_in[3]));
endmodule // pin_remap_lock

// [include/pin_remap_pkg.sv]
// constants, states and carriers for the pin remap lock and input select block
package pin_remap_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int SEL_W = 5;
    localparam int NUM_RP = 26;
    localparam int NUM_IN_REGS = 16;
    localparam int NUM_OUT_REGS = 13;
    localparam int NUM_AN = 16;
    localparam int NUM_PERIPH = 32;
    localparam int EV_W = 3;

    localparam logic [7:0] OFS_OSC_CTRL = 8'h00;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h01;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h02;
    localparam logic [7:0] OFS_ANA_CFG1 = 8'h03;
    localparam logic [7:0] OFS_ANA_CFG2 = 8'h04;
    localparam logic [7:0] OFS_IN_MAP_BASE = 8'h10;
    localparam logic [7:0] OFS_OUT_MAP_BASE = 8'h20;

    localparam int LOCK_BIT = 6;
    localparam int SINGLE_SESSION_BIT = 5;
    localparam int FIELD_LO = 0;
    localparam int FIELD_HI = 8;
    localparam int EV_MISMATCH = 0;
    localparam int EV_BLOCKED = 1;
    localparam int EV_LOCK_CHG = 2;

    localparam logic [7:0] UNLOCK_KEY1 = 8'h46;
    localparam logic [7:0] UNLOCK_KEY2 = 8'h57;
    localparam logic [4:0] SEL_TIED_LOW = 5'h1F;
    localparam logic [4:0] SEL_LAST_PIN = 5'h19;
    localparam logic [4:0] OUT_NULL = 5'h00;

    localparam logic [15:0] IN0_MASK = 16'h1F00;
    localparam logic [15:0] IN_MASK = 16'h1F1F;
    localparam logic [15:0] IN0_RESET = 16'h1F00;
    localparam logic [15:0] IN_RESET = 16'h1F1F;
    localparam logic [15:0] OUT_MASK = 16'h1F1F;
    localparam logic [15:0] OUT_RESET = 16'h0000;
    localparam logic [15:0] ANA_CFG_RESET = 16'h0000;
    localparam logic [EV_W-1:0] EV_MASK_RESET = 3'h0;

    typedef enum logic [1:0] {KEY_IDLE, KEY_GOT1, KEY_GOT2} key_state_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    typedef struct packed {
        logic [NUM_RP-1:0] out;
        logic [NUM_RP-1:0] oe;
    } pad_drive_s;
endpackage

// [testbench/pin_remap_lock_test.sv]
// self-checking bench for the pin remap lock and input select block
`timescale 1ns/1ps
module pin_remap_lock_test
    import pin_remap_pkg::*;
;
    logic ref_clk;
    logic reset_n;
    reg_req_s bus_req;
    logic [DATA_W-1:0] rdata;
    logic irq;
    logic [7:0] osc_config_word;
    logic [NUM_RP-1:0] pad_in;
    pad_drive_s pad_drive;
    logic [NUM_RP-1:0] port_out;
    logic [NUM_RP-1:0] pin_direction_reg;
    logic [NUM_PERIPH-1:0] periph_out;
    logic [NUM_RP-1:0] digital_in;
    logic ext_irq1_input;
    logic mapping_write_lock;
    logic cfg_mismatch_reset;
    int n_fail;
    int check_count;

    pin_remap_lock i_pin_remap_lock (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .bus_req(bus_req),
        .rdata(rdata),
        .irq(irq),
        .osc_config_word(osc_config_word),
        .pad_in(pad_in),
        .pad_drive(pad_drive),
        .port_out(port_out),
        .pin_direction_reg(pin_direction_reg),
        .periph_out(periph_out),
        .digital_in(digital_in),
        .ext_irq1_input(ext_irq1_input),
        .mapping_write_lock(mapping_write_lock),
        .cfg_mismatch_reset(cfg_mismatch_reset)
    );

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic end_of_test();
        if (n_fail == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic pause(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus_req <= '0;
    endtask

    // read data stand only in the cycle after the strobe, so sample just after that edge
    task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus_req <= '0;
        #1;
        chk({16'h0000, rdata}, {16'h0000, exp});
    endtask

    task automatic lock_seq(input logic [15:0] v);
        wr(OFS_OSC_CTRL, {8'h00, UNLOCK_KEY1});
        wr(OFS_OSC_CTRL, {8'h00, UNLOCK_KEY2});
        wr(OFS_OSC_CTRL, v);
    endtask

    task automatic do_reset(input logic [7:0] cfg);
        @(posedge ref_clk);
        osc_config_word <= cfg;
        reset_n <= 1'b0;
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
    endtask

    // cuts a hang short; far above the length of the main sequence
    initial begin
        #(50 * 20000);
        n_fail++;
        end_of_test();
    end

    initial begin
        n_fail = 0;
        check_count = 0;
        reset_n = 1'b0;
        bus_req = '0;
        osc_config_word = 8'h00;
        pad_in = '0;
        port_out = 26'h0000002;
        pin_direction_reg = '1;
        periph_out = 32'h00000008;
        do_reset(8'h00);
        rdc(OFS_IN_MAP_BASE, IN0_RESET);
        rdc(OFS_IN_MAP_BASE + 8'h0F, IN_RESET);
        rdc(OFS_OUT_MAP_BASE + 8'h0C, OUT_RESET);
        wr(OFS_IN_MAP_BASE, 16'hFFFF);
        rdc(OFS_IN_MAP_BASE, 16'h1F00);
        wr(OFS_IRQ_MASK, 16'h0002);
        lock_seq(16'h0040);
        pause(1);
        chk(mapping_write_lock, 1'b1);
        rdc(OFS_OSC_CTRL, 16'h0040);
        chk(irq, 1'b0);
        wr(OFS_IN_MAP_BASE, 16'h0300);
        wr(OFS_OUT_MAP_BASE, 16'h0003);
        pause(1);
        chk(irq, 1'b1);
        rdc(OFS_IN_MAP_BASE, 16'h1F00);
        rdc(OFS_OUT_MAP_BASE, OUT_RESET);
        rdc(OFS_IRQ_STATUS, 16'h0006);
        pause(1);
        chk(irq, 1'b0);
        rdc(OFS_IRQ_STATUS, 16'h0000);
        // a read between the keys breaks the sequence
        wr(OFS_OSC_CTRL, {8'h00, UNLOCK_KEY1});
        rdc(OFS_OSC_CTRL, 16'h0040);
        wr(OFS_OSC_CTRL, {8'h00, UNLOCK_KEY2});
        wr(OFS_OSC_CTRL, 16'h0000);
        pause(1);
        chk(mapping_write_lock, 1'b1);
        wr(OFS_OSC_CTRL, {8'h00, UNLOCK_KEY1});
        wr(OFS_OSC_CTRL, {8'h00, UNLOCK_KEY2 + 8'h01});
        wr(OFS_OSC_CTRL, 16'h0000);
        pause(1);
        chk(mapping_write_lock, 1'b1);
        lock_seq(16'h0000);
        pause(1);
        chk(mapping_write_lock, 1'b0);
        wr(OFS_IN_MAP_BASE, 16'h0300);
        wr(OFS_OUT_MAP_BASE, 16'h0003);
        rdc(OFS_IN_MAP_BASE, 16'h0300);
        rdc(OFS_OUT_MAP_BASE, 16'h0003);
        chk(cfg_mismatch_reset, 1'b0);
        // pins 0 and 1 drive while still analog: pin 0 from peripheral 3, pin 1 from port
        @(posedge ref_clk);
        pin_direction_reg <= ~26'h0000003;
        pad_in <= 26'h2000008;
        pause(8);
        chk(pad_drive.oe[1:0], 2'b11);
        chk(pad_drive.out[1:0], 2'b11);
        chk(digital_in[3], 1'b0);
        chk(ext_irq1_input, 1'b0);
        wr(OFS_ANA_CFG1, 16'h0008);
        pause(8);
        chk(digital_in[3], 1'b0);
        wr(OFS_ANA_CFG2, 16'h0008);
        pause(8);
        chk(digital_in[3], 1'b1);
        chk(ext_irq1_input, 1'b1);
        @(posedge ref_clk);
        pad_in <= 26'h2000000;
        pause(8);
        chk(ext_irq1_input, 1'b0);
        wr(OFS_IN_MAP_BASE, {3'b000, SEL_LAST_PIN, 8'h00});
        pause(8);
        chk(ext_irq1_input, 1'b1);
        wr(OFS_IN_MAP_BASE, {3'b000, SEL_TIED_LOW, 8'h00});
        pause(8);
        chk(ext_irq1_input, 1'b0);
        // one-session option: the lock sticks once set until the next reset
        @(posedge ref_clk);
        pad_in <= 26'h0000008;
        do_reset(8'h20);
        pause(8);
        chk(mapping_write_lock, 1'b0);
        chk(digital_in[3], 1'b0);
        lock_seq(16'h0040);
        pause(1);
        chk(mapping_write_lock, 1'b1);
        lock_seq(16'h0000);
        pause(1);
        chk(mapping_write_lock, 1'b1);
        wr(OFS_IN_MAP_BASE, 16'h0500);
        rdc(OFS_IN_MAP_BASE, IN0_RESET);
        do_reset(8'h20);
        wr(OFS_IN_MAP_BASE, 16'h0500);
        rdc(OFS_IN_MAP_BASE, 16'h0500);
        end_of_test();
    end
endmodule // pin_remap_lock_test
